// *** bench/clcsel_props.sv ***
// assertion checker for the logic cell input select block
`timescale 1ns/1ps
`default_nettype none
module clcsel_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [3:0]  gate_o,
  input wire logic        cell_out_o,
  input wire logic        irq_o
);
  logic [1:0] con_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of module and interrupt enables
  always @(posedge clk_i) begin
    if (rst_i)
      con_q <= 2'h0;
    else if (ack_o && we_i && adr_i == 4'h0 && sel_i[0])
      con_q <= dat_i[1:0];
  end
  property p_taken; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_taken: assert property (p_taken) else $error("request not acknowledged next cycle");
  property p_drop; ack_o |=> !ack_o; endproperty
  a_drop: assert property (p_drop) else $error("acknowledge longer than one cycle");
  property p_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
  a_idle: assert property (p_idle) else $error("acknowledge without request");
  property p_rst; $fell(rst_i) |-> gate_o == 4'h0 && !cell_out_o && !irq_o && dat_o == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_sel_rd; ack_o && !we_i && adr_i == 4'h4 |-> (dat_o & 32'hFFFF8888) == 32'h0; endproperty
  a_sel_rd: assert property (p_sel_rd) else $error("unimplemented select bits read nonzero");
  property p_hold; !ack_o |-> $stable(dat_o); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without access");
  property p_gate_off; !con_q[0] [*4] |-> gate_o == 4'h0 && !cell_out_o; endproperty
  a_gate_off: assert property (p_gate_off) else $error("gates active while disabled");
  property p_irq_off; !con_q[1] [*3] |-> !irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while interrupt disabled");
endmodule // clcsel_props
bind clcsel_top clcsel_props u_props (.*);
`default_nettype wire

// *** bench/clcsel_src_model.sv ***
// far side: peripheral events and input pins feeding the selectors
`timescale 1ns/1ps
`default_nettype none
module clcsel_src_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] val_i,
  output var  logic [7:0]  mux1_o,
  output var  logic [7:0]  mux2_o,
  output var  logic [7:0]  mux3_o,
  output var  logic [7:0]  mux4_o,
  output wire logic        serial_interface_two_o
);
  always @(posedge clk_i) begin
    {mux4_o, mux3_o, mux2_o, mux1_o} <= val_i;
  end
  // other serial line always differs from the first
  assign serial_interface_two_o = ~mux4_o[3];
endmodule // clcsel_src_model
`default_nettype wire

// *** bench/clcsel_top_test.sv ***
// self-checking bench for the logic cell input select block
`timescale 1ns/1ps
`default_nettype none
`include "clcsel_defines.vh"
module clcsel_top_test;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [3:0]  adr_i = 0, sel_i = 0, gate_o;
  logic [31:0] dat_i = 0, dat_o, val = 0, rd, sv, gv, cv;
  logic        ack_o, cell_out_o, irq_o, serial_interface_two;
  logic        ack2, out2, irq2;
  logic [3:0]  gate2;
  logic [4:0]  ex;
  logic [31:0] dat_o2, rd2;
  logic [7:0]  m1, m2, m3, m4;
  logic [3:0]  adrs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  integer      mismatches = 0, comparisons = 0, seed = 32'hb7e0e346, i;
  always #5 clk_i = ~clk_i;
  clcsel_src_model u_src (.clk_i(clk_i), .val_i(val), .mux1_o(m1), .mux2_o(m2), .mux3_o(m3), .mux4_o(m4),
    .serial_interface_two_o(serial_interface_two));
  clcsel_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mux1_src_i(m1), .mux2_src_i(m2), .mux3_src_i(m3),
    .cell_input_pin_b_i(m4[0]), .other_cell_out_i(m4[1]), .capture_unit_three_output_i(m4[2]),
    .serial_interface_one_data_i(m4[3]), .serial_interface_two_data_i(serial_interface_two), .calendar_clock_event_i(m4[5]),
    .multi_output_capture_unit_one_match_i(m4[6]), .capture_unit_three_match_i(m4[7]), .gate_o(gate_o),
    .cell_out_o(cell_out_o), .irq_o(irq_o));
  clcsel_top #(.CELL_INDEX(2)) u_dut_two (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o2), .ack_o(ack2), .mux1_src_i(m1),
    .mux2_src_i(m2), .mux3_src_i(m3), .cell_input_pin_b_i(m4[0]), .other_cell_out_i(m4[1]),
    .capture_unit_three_output_i(m4[2]), .serial_interface_one_data_i(m4[3]), .serial_interface_two_data_i(serial_interface_two),
    .calendar_clock_event_i(m4[5]), .multi_output_capture_unit_one_match_i(m4[6]),
    .capture_unit_three_match_i(m4[7]), .gate_o(gate2), .cell_out_o(out2), .irq_o(irq2));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    rd2 = dat_o2;
    chk("cell two ack", ack2, 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [4:0] expect_out(input logic [31:0] c, g, s, v, input logic two);
    logic [3:0] m, gt;
    m = {v[24 + s[14:12]] & (s[14:12] != 3'h4), v[16 + s[10:8]], v[8 + s[6:4]], v[s[2:0]]};
    // second cell takes the other serial line, which the model drives inverted
    if (two && s[14:12] == 3'h3)
      m[3] = ~v[27];
    for (int k = 0; k < 4; k++)
      gt[k] = c[0] & (c[4 + k] ^ |(g[8 * k +: 8] & {~m[3], m[3], ~m[2], m[2], ~m[1], m[1], ~m[0], m[0]}));
    return {c[0] & c[2] & (c[3] ^ (gt[0] & gt[1] | gt[2] & gt[3])), gt};
  endfunction
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (adrs[j]) begin
      bus(1'b0, adrs[j], 4'hF, 32'h0);
      chk("reset read", rd, 32'h0);
    end
    for (i = 0; i < 48; i++) begin
      cv = $random(seed) | (i < 40);
      gv = $random(seed);
      sv = $random(seed);
      sv[14:12] = i[2:0];
      val <= $random(seed);
      bus(1'b1, `CLCSEL_CON_OFF, 4'hF, cv);
      bus(1'b1, `CLCSEL_SEL_OFF, 4'hF, sv);
      bus(1'b1, `CLCSEL_GLS_OFF, 4'hF, gv);
      bus(1'b0, `CLCSEL_SEL_OFF, 4'hF, 32'h0);
      chk("select readback", rd, sv & 32'h00007777);
      chk("cell two select", rd2, sv & 32'h00007777);
      bus(1'b0, `CLCSEL_CON_OFF, 4'hF, 32'h0);
      chk("control readback", rd, cv & 32'h000000FF);
      repeat (4) @(posedge clk_i);
      ex = expect_out(cv, gv, sv, val, 1'b0);
      chk("cell one", {cell_out_o, gate_o}, ex);
      chk("cell two", {out2, gate2}, expect_out(cv, gv, sv, val, 1'b1));
    end
    bus(1'b1, `CLCSEL_GLS_OFF, 4'hF, 32'h0);
    bus(1'b1, `CLCSEL_CON_OFF, 4'hF, 32'h7);
    repeat (5) @(posedge clk_i);
    bus(1'b1, `CLCSEL_STAT_OFF, 4'h1, 32'h3);
    bus(1'b1, `CLCSEL_CON_OFF, 4'hF, 32'hF);
    repeat (5) @(posedge clk_i);
    chk("masked irq", {irq2, irq_o}, 2'h0);
    bus(1'b0, `CLCSEL_STAT_OFF, 4'hF, 32'h0);
    chk("status rise", rd, 32'h1);
    chk("cell two status rise", rd2, 32'h1);
    bus(1'b1, 4'hD, 4'h1, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("unmasked irq", {irq2, irq_o}, 2'h3);
    bus(1'b1, `CLCSEL_STAT_OFF, 4'h1, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("cleared irq", {irq2, irq_o}, 2'h0);
    bus(1'b0, `CLCSEL_STAT_OFF, 4'hF, 32'h0);
    chk("status after clear", rd, 32'h100);
    chk("cell two status after clear", rd2, 32'h100);
    // reset in mid-run must clear everything again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, `CLCSEL_SEL_OFF, 4'hF, 32'h0);
    chk("select after reset", rd, 32'h0);
    chk("cell two select after reset", rd2, 32'h0);
    chk("outputs after reset", {irq2, out2, gate2, irq_o, cell_out_o, gate_o}, 32'h0);
    finish_test();
  end
endmodule // clcsel_top_test
`default_nettype wire

// *** logic/clcsel_defines.vh ***
// register offsets, field positions and source codes of the logic cell input select block
`ifndef CLCSEL_DEFINES_VH
`define CLCSEL_DEFINES_VH

// register byte offsets
`define CLCSEL_CON_OFF       4'h0
`define CLCSEL_SEL_OFF       4'h4
`define CLCSEL_GLS_OFF       4'h8
`define CLCSEL_STAT_OFF      4'hC

// select register fields
`define CLCSEL_SEL_MASK      32'h00007777
`define CLCSEL_SEL_RST       32'h00000000
`define CLCSEL_DS_W          3
`define CLCSEL_DS_STRIDE     4

// control register fields
`define CLCSEL_CON_MASK      32'h000000FF
`define CLCSEL_CON_RST       32'h00000000
`define CLCSEL_CON_EN        0
`define CLCSEL_CON_IE        1
`define CLCSEL_CON_OE        2
`define CLCSEL_CON_POL       3
`define CLCSEL_CON_GPOL_LO   4
`define CLCSEL_CON_GPOL_HI   7

// gate select register: 8 enable bits per gate, 4 gates
`define CLCSEL_GLS_RST       32'h00000000
`define CLCSEL_GLS_MASK      32'hFFFFFFFF
`define CLCSEL_GLS_W         8

// status / mask register: events in bits 1:0
`define CLCSEL_STAT_RISE     0
`define CLCSEL_STAT_FALL     1
`define CLCSEL_STAT_MASK_OFF 4'hD

// mux4 source codes
`define CLCSEL_SRC_PIN_B     3'h0
`define CLCSEL_SRC_OTHER     3'h1
`define CLCSEL_SRC_CAP3_OUT  3'h2
`define CLCSEL_SRC_SPI_IN    3'h3
`define CLCSEL_SRC_RSVD      3'h4
`define CLCSEL_SRC_CAL       3'h5
`define CLCSEL_SRC_MCAP1     3'h6
`define CLCSEL_SRC_CAP3_CMP  3'h7

`endif

// *** logic/clcsel_gate.v ***
// one input gate: OR of the enabled true and inverted mux signals
`timescale 1ns/1ps
`default_nettype none

module clcsel_gate (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] sig_i,
  input  wire [7:0] ena_i,
  input  wire       pol_i,
  output reg        gate_o
);

  // ****************************************
  // or gate with polarity
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_o <= 1'b0;
    end else begin
      gate_o <= (|(sig_i & ena_i)) ^ pol_i;
    end
  end

endmodule // clcsel_gate
`default_nettype wire

// *** logic/clcsel_mux.v ***
// one eight-way data selection multiplexer with true and inverted outputs
`timescale 1ns/1ps
`default_nettype none
`include "clcsel_defines.vh"

module clcsel_mux (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [2:0] code_i,
  input  wire [7:0] src_i,
  output reg        true_o,
  output reg        neg_o
);

  // ****************************************
  // selection
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      true_o <= 1'b0;
      neg_o  <= 1'b1;
    end else begin
      true_o <= src_i[code_i];
      neg_o  <= ~src_i[code_i];
    end
  end

endmodule // clcsel_mux
`default_nettype wire

// *** logic/clcsel_top.v ***
// input selection and gating front end of a configurable logic cell, Wishbone slave
// Operation
// - there are four independent data selection multiplexers per cell.
// - each multiplexer picks one of eight sources by a three-bit code in the select register.
// - each multiplexer offers its selected signal and its inverse to the gates.
// - each input gate ORs whichever of the eight true and inverted signals are enabled for it.
// - the gate select register chooses per gate which mux signals are enabled.
// - the control register holds module, interrupt and output enables, output polarity and the four gate polarities.
// - software may invert intermediate gate signals and the final output.
// - the fourth multiplexer code sits at bits 14 to 12 of the select register.
// - mux four codes 7,6,5,2,0 are capture three match, multi capture one match, calendar, capture three out, pin B; 4 reserved.
// - in cell one, mux four code 3 is serial one data in and code 1 is cell two output.
// - in cell two, mux four code 3 is serial two data in and code 1 is cell one output.
// - select register bits 31 to 15 and bit 11 read as zero.
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "clcsel_defines.vh"

module clcsel_top #(
  parameter CELL_INDEX = 1
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // sources for muxes 1..3 (eight each)
  input  wire [7:0]  mux1_src_i,
  input  wire [7:0]  mux2_src_i,
  input  wire [7:0]  mux3_src_i,
  // mux4 sources
  input  wire        cell_input_pin_b_i,
  input  wire        other_cell_out_i,
  input  wire        capture_unit_three_output_i,
  input  wire        serial_interface_one_data_i,
  input  wire        serial_interface_two_data_i,
  input  wire        calendar_clock_event_i,
  input  wire        multi_output_capture_unit_one_match_i,
  input  wire        capture_unit_three_match_i,
  // results
  output reg  [3:0]  gate_o,
  output reg         cell_out_o,
  output reg         irq_o
);

  // ****************************************
  // registers
  // ****************************************
  reg  [31:0] cell_control_reg_q;
  reg  [31:0] cell_input_mux_select_reg_q;
  reg  [31:0] cell_gate_input_select_reg_q;
  reg  [1:0]  irq_stat_q;
  reg  [1:0]  irq_mask_q;
  reg         prev_out_q;

  wire        req      = cyc_i & stb_i & ~ack_o;
  // write lands at the acknowledge edge
  wire        wr       = cyc_i & stb_i & we_i & ack_o;
  wire [31:0] be_mask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [3:0]  gate_w;
  wire [7:0]  mux_sig;
  wire [7:0]  mux4_src;
  wire [1:0]  events;

  // byte-enabled merge of write data into an old value under a field mask
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] bm;
    input [31:0] fm;
    begin
      merge = ((old_v & ~bm) | (new_v & bm)) & fm;
    end
  endfunction

  // ****************************************
  // mux4 source wiring
  // ****************************************
  generate
    if (CELL_INDEX == 1) begin : g_cell_one
      assign mux4_src[3] = serial_interface_one_data_i;
    end else begin : g_cell_two
      assign mux4_src[3] = serial_interface_two_data_i;
    end
  endgenerate
  assign mux4_src[0] = cell_input_pin_b_i;
  assign mux4_src[1] = other_cell_out_i;
  assign mux4_src[2] = capture_unit_three_output_i;
  assign mux4_src[4] = 1'b0;
  assign mux4_src[5] = calendar_clock_event_i;
  assign mux4_src[6] = multi_output_capture_unit_one_match_i;
  assign mux4_src[7] = capture_unit_three_match_i;

  // ****************************************
  // selection multiplexers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mux
      wire [7:0] src = (gi == 0) ? mux1_src_i :
                       (gi == 1) ? mux2_src_i :
                       (gi == 2) ? mux3_src_i : mux4_src;
      clcsel_mux u_mux (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .code_i (cell_input_mux_select_reg_q[gi*`CLCSEL_DS_STRIDE +: `CLCSEL_DS_W]),
        .src_i  (src),
        .true_o (mux_sig[2*gi]),
        .neg_o  (mux_sig[2*gi+1])
      );
      clcsel_gate u_gate (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .sig_i  (mux_sig),
        .ena_i  (cell_gate_input_select_reg_q[gi*`CLCSEL_GLS_W +: `CLCSEL_GLS_W]),
        .pol_i  (cell_control_reg_q[`CLCSEL_CON_GPOL_LO + gi]),
        .gate_o (gate_w[gi])
      );
    end
  endgenerate

  // ****************************************
  // output stage: simple and-or function
  // ****************************************
  wire cell_raw = ((gate_w[0] & gate_w[1]) | (gate_w[2] & gate_w[3]))
                  ^ cell_control_reg_q[`CLCSEL_CON_POL];
  wire cell_en  = cell_control_reg_q[`CLCSEL_CON_EN];
  wire cell_val = cell_en & cell_raw;

  assign events = {prev_out_q & ~cell_val, ~prev_out_q & cell_val};

  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_o     <= 4'h0;
      cell_out_o <= 1'b0;
      prev_out_q <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      gate_o     <= cell_en ? gate_w : 4'h0;
      cell_out_o <= cell_val & cell_control_reg_q[`CLCSEL_CON_OE];
      prev_out_q <= cell_val;
      irq_o      <= cell_control_reg_q[`CLCSEL_CON_IE] & (|(irq_stat_q & irq_mask_q));
    end
  end

  // ****************************************
  // wishbone register access
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      cell_control_reg_q           <= `CLCSEL_CON_RST;
      cell_input_mux_select_reg_q  <= `CLCSEL_SEL_RST;
      cell_gate_input_select_reg_q <= `CLCSEL_GLS_RST;
      irq_stat_q                   <= 2'h0;
      irq_mask_q                   <= 2'h0;
      ack_o                        <= 1'b0;
      dat_o                        <= 32'h00000000;
    end else begin
      ack_o <= req;
      // set wins over write-one-to-clear
      irq_stat_q <= (irq_stat_q & ~((wr && adr_i == `CLCSEL_STAT_OFF && sel_i[0]) ? dat_i[1:0] : 2'h0))
                    | (cell_en ? events : 2'h0);
      if (wr) begin
        if (adr_i == `CLCSEL_CON_OFF) begin
          cell_control_reg_q <= merge(cell_control_reg_q, dat_i, be_mask, `CLCSEL_CON_MASK);
        end else if (adr_i == `CLCSEL_SEL_OFF) begin
          cell_input_mux_select_reg_q <= merge(cell_input_mux_select_reg_q, dat_i, be_mask,
                                               `CLCSEL_SEL_MASK);
        end else if (adr_i == `CLCSEL_GLS_OFF) begin
          cell_gate_input_select_reg_q <= merge(cell_gate_input_select_reg_q, dat_i, be_mask, `CLCSEL_GLS_MASK);
        end else if (adr_i == `CLCSEL_STAT_MASK_OFF && sel_i[0]) begin
          irq_mask_q <= dat_i[1:0];
        end
      end
      if (req && !we_i) begin
        if (adr_i == `CLCSEL_CON_OFF) begin
          dat_o <= cell_control_reg_q;
        end else if (adr_i == `CLCSEL_SEL_OFF) begin
          dat_o <= cell_input_mux_select_reg_q & `CLCSEL_SEL_MASK;
        end else if (adr_i == `CLCSEL_GLS_OFF) begin
          dat_o <= cell_gate_input_select_reg_q;
        end else if (adr_i == `CLCSEL_STAT_OFF) begin
          dat_o <= {22'h000000, irq_mask_q, 6'h00, irq_stat_q};
        end else begin
          dat_o <= 32'h00000000;
        end
      end
    end
  end

endmodule // clcsel_top
`default_nettype wire
